// ### src/fcc_pkg.sv
// package: register map, field layout and types of the flash code checker
package fcc_pkg;
    // register offsets
    localparam logic [7:0] FCC_SUSPEND_KEY_ADDR = 8'h8e;
    localparam logic [7:0] FCC_POWER_CONTROL_ADDR = 8'h87;
    localparam logic [7:0] FCC_CHECK_CONTROL_ADDR = 8'hac;
    localparam logic [7:0] FCC_RESULT_LOW_ADDR = 8'had;
    localparam logic [7:0] FCC_RESULT_HIGH_ADDR = 8'hae;
    localparam logic [7:0] FCC_IRQ_STATUS_ADDR = 8'hb8;
    localparam logic [7:0] FCC_IRQ_ENABLE_ADDR = 8'hb9;
    localparam logic [7:0] FCC_IRQ_CLEAR_ADDR = 8'hba;
    // control field positions
    localparam int FCC_START_BIT = 7;
    localparam int FCC_DONE_BIT = 6;
    localparam int FCC_IDLE_BIT = 0;
    localparam int FCC_PDOWN_BIT = 1;
    // irq status/enable layout
    localparam int FCC_EV_DONE = 0;
    localparam int FCC_EV_WAKE = 1;
    localparam int FCC_EV_N = 2;
    // reset values and constants
    localparam logic [7:0] FCC_BYTE_RESET = 8'h00;
    localparam logic [7:0] FCC_SUSPEND_KEY_VALUE = 8'h55;
    localparam logic [15:0] FCC_POLY = 16'h1021;
    localparam logic [15:0] FCC_SPAN_UNIT = 16'h0800;
    localparam logic [15:0] FCC_TAIL_BYTES = 16'h0002;
    localparam int FCC_MAX_RANGE = 15;

    typedef enum logic [1:0] {FCC_IDLE, FCC_FETCH, FCC_WAIT} fcc_state_t;

    // register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } fcc_bus_t;

    // flash port towards the program memory
    typedef struct packed {
        logic req;
        logic [15:0] addr;
    } fcc_flash_req_t;
endpackage

// ### src/fcc_crc_byte.sv
// crc step: folds one byte into the 16-bit code, msb first
`timescale 1ns/10ps
module fcc_crc_byte
    import fcc_pkg::*;
(
    input wire logic [15:0] crc_in,
    input wire logic [7:0] data_in,
    output logic [15:0] crc_out
);
    logic [15:0] stage [0:8];

    assign stage[0] = crc_in;
    // one polynomial shift per data bit, bit 7 first
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_bit
            assign stage[i+1] = (stage[i][15] ^ data_in[7-i])
                ? ({stage[i][14:0], 1'b0} ^ FCC_POLY) : {stage[i][14:0], 1'b0};
        end
    endgenerate
    assign crc_out = stage[8];
endmodule

// ### src/fcc_checker.sv
// flash code checker: crc engine, control registers, suspend sequencing
//
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
//
// Function
// - crc-ccitt polynomial, msb first per byte
// - range select sets span from address zero
// - last two bytes of span skipped
// - start bit one runs, zero disables
// - completion clears start, sets done flag
// - check_irq needs shared and own enables, irq only the own enable
// - done flag cleared only by software
// - result bytes updated after every folded byte
// - normal mode runs beside the cpu
// - idle mode speeds up, irq wakes cpu
// - key 55h then request, else cleared
// - interrupt or reset clears request bits
module fcc_checker
    import fcc_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    input wire fcc_bus_t bus,
    output logic [7:0] rdata,
    output fcc_flash_req_t flash,
    input wire logic flash_busy,
    input wire logic [7:0] flash_data,
    input wire logic shared_irq_enable,
    input wire logic other_wake_irq,
    output logic check_irq,
    output logic irq,
    output logic idle_active,
    output logic powerdown_active
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        fcc_state_t state;
        logic check_start;
        logic check_done_flag;
        logic check_irq_enable;
        logic [3:0] check_range_select;
        logic [15:0] check_result_value;
        logic [15:0] addr;
        logic [7:0] suspend_key;
        logic key_armed;
        logic idle_request_bit;
        logic powerdown_request_bit;
        logic [FCC_EV_N-1:0] irq_status;
        logic [FCC_EV_N-1:0] irq_enable;
        logic [7:0] rdata;
    } fcc_regs_t;

    fcc_regs_t s_reg;
    fcc_regs_t s_next;
    logic [15:0] crc_step;
    logic [15:0] last_addr;
    logic done_now;
    logic wake_now;
    logic sel_key;
    logic sel_power_control;
    logic sel_ctrl;
    logic sel_lo;
    logic sel_hi;

    // address compare used by every register select
    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        return a == b;
    endfunction

    // last byte address taking part: span end minus the two tail bytes
    function automatic logic [15:0] span_last(input logic [3:0] r);
        logic [15:0] span;
        span = FCC_SPAN_UNIT * ({12'h000, r} + 16'h0001);
        return span - FCC_TAIL_BYTES - 16'h0001;
    endfunction

    fcc_crc_byte u_step (
        .crc_in(s_reg.check_result_value),
        .data_in(flash_data),
        .crc_out(crc_step)
    );

    // ------------------------------------------------------------
    // decode and events
    // ------------------------------------------------------------
    assign sel_key = hit(bus.addr, FCC_SUSPEND_KEY_ADDR);
    assign sel_power_control = hit(bus.addr, FCC_POWER_CONTROL_ADDR);
    assign sel_ctrl = hit(bus.addr, FCC_CHECK_CONTROL_ADDR);
    assign sel_lo = hit(bus.addr, FCC_RESULT_LOW_ADDR);
    assign sel_hi = hit(bus.addr, FCC_RESULT_HIGH_ADDR);
    assign last_addr = span_last(s_reg.check_range_select);
    // last byte folded in this cycle
    assign done_now = (s_reg.state == FCC_WAIT) && (s_reg.addr == last_addr);
    // any wake source ends the suspend state
    assign wake_now = irq || other_wake_irq;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.rdata = FCC_BYTE_RESET;
        // engine sequencing
        case (s_reg.state)
            FCC_IDLE: begin
                if (s_reg.check_start) begin
                    s_next.state = FCC_FETCH;
                end
            end
            FCC_FETCH: begin
                if (!flash_busy) begin
                    s_next.state = FCC_WAIT;
                end
            end
            FCC_WAIT: begin
                s_next.check_result_value = crc_step;
                if (done_now) begin
                    s_next.state = FCC_IDLE;
                    s_next.check_start = 1'b0;
                    s_next.check_done_flag = 1'b1;
                end else begin
                    s_next.addr = s_reg.addr + 16'h0001;
                    s_next.state = FCC_FETCH;
                end
            end
            default: begin
                s_next.state = FCC_IDLE;
            end
        endcase
        // software write side
        if (bus.wr) begin
            if (sel_ctrl) begin
                if (!bus.wdata[FCC_START_BIT]) begin
                    s_next.check_start = 1'b0;
                    s_next.state = FCC_IDLE;
                end else if (s_reg.state == FCC_IDLE && !s_reg.check_start) begin
                    s_next.check_start = 1'b1;
                    s_next.addr = 16'h0000;
                end
                if (!bus.wdata[FCC_DONE_BIT] && !done_now) begin
                    s_next.check_done_flag = 1'b0;
                end
                s_next.check_range_select = bus.wdata[3:0];
            end
            if (sel_lo) begin
                s_next.check_result_value[7:0] = bus.wdata;
            end
            if (sel_hi) begin
                s_next.check_result_value[15:8] = bus.wdata;
            end
            if (hit(bus.addr, FCC_IRQ_ENABLE_ADDR)) begin
                s_next.irq_enable = bus.wdata[FCC_EV_N-1:0];
                s_next.check_irq_enable = bus.wdata[FCC_EV_DONE];
            end
            if (hit(bus.addr, FCC_IRQ_CLEAR_ADDR)) begin
                s_next.irq_status = s_reg.irq_status & ~bus.wdata[FCC_EV_N-1:0];
            end
        end
        // suspend key: only the very next write may be the request
        // idle bus cycles between the two writes keep the key armed
        if (bus.wr) begin
            s_next.key_armed = 1'b0;
        end
        if (bus.wr && sel_key) begin
            s_next.suspend_key = bus.wdata;
            s_next.key_armed = (bus.wdata == FCC_SUSPEND_KEY_VALUE);
        end else if (bus.wr && sel_power_control && s_reg.key_armed) begin
            s_next.idle_request_bit = bus.wdata[FCC_IDLE_BIT];
            s_next.powerdown_request_bit = bus.wdata[FCC_PDOWN_BIT];
        end else if (bus.wr) begin
            s_next.suspend_key = FCC_BYTE_RESET;
        end
        // wake clears the request bits and the key
        if (wake_now) begin
            s_next.idle_request_bit = 1'b0;
            s_next.powerdown_request_bit = 1'b0;
            s_next.suspend_key = FCC_BYTE_RESET;
            s_next.key_armed = 1'b0;
        end
        // sticky events, set wins over clear
        if (done_now) begin
            s_next.irq_status[FCC_EV_DONE] = 1'b1;
        end
        if (wake_now && (s_reg.idle_request_bit || s_reg.powerdown_request_bit)) begin
            s_next.irq_status[FCC_EV_WAKE] = 1'b1;
        end
        // read data, one cycle later
        if (bus.rd) begin
            if (sel_key) begin
                s_next.rdata = s_reg.suspend_key;
            end else if (sel_power_control) begin
                s_next.rdata = {6'h00, s_reg.powerdown_request_bit, s_reg.idle_request_bit};
            end else if (sel_ctrl) begin
                s_next.rdata = {s_reg.check_start, s_reg.check_done_flag, 2'b00,
                                s_reg.check_range_select};
            end else if (sel_lo) begin
                s_next.rdata = s_reg.check_result_value[7:0];
            end else if (sel_hi) begin
                s_next.rdata = s_reg.check_result_value[15:8];
            end else if (hit(bus.addr, FCC_IRQ_STATUS_ADDR)) begin
                s_next.rdata = {6'h00, s_reg.irq_status};
            end else if (hit(bus.addr, FCC_IRQ_ENABLE_ADDR)) begin
                s_next.rdata = {6'h00, s_reg.irq_enable};
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            s_reg <= '0;
        end else if (clk_en) begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rdata = s_reg.rdata;
    assign flash.req = (s_reg.state == FCC_FETCH) && !flash_busy;
    assign flash.addr = s_reg.addr;
    // completion irq to the cpu needs both enables
    assign check_irq = s_reg.check_done_flag && s_reg.check_irq_enable
                       && shared_irq_enable;
    assign irq = |(s_reg.irq_status & s_reg.irq_enable) || check_irq;
    assign idle_active = s_reg.idle_request_bit && !s_reg.powerdown_request_bit;
    assign powerdown_active = s_reg.powerdown_request_bit;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    // completion clears start and sets the done flag
    a_done_clears_start: assert property (@(posedge clock) disable iff (rst)
        clk_en && done_now && !bus.wr |=> s_reg.check_done_flag && !s_reg.check_start)
        else $error("completion did not set done and clear start");

    // completion also raises the sticky status bit
    a_done_status: assert property (@(posedge clock) disable iff (rst)
        clk_en && done_now |=> s_reg.irq_status[FCC_EV_DONE])
        else $error("completion did not set the status bit");

    // only a software write of the control register drops the done flag
    a_done_sticky: assert property (@(posedge clock) disable iff (rst)
        s_reg.check_done_flag && !(bus.wr && sel_ctrl) |=> s_reg.check_done_flag)
        else $error("done flag dropped without software clear");

    // a start from rest launches at address zero
    a_start_runs: assert property (@(posedge clock) disable iff (rst)
        clk_en && bus.wr && sel_ctrl && bus.wdata[FCC_START_BIT] && s_reg.state == FCC_IDLE
        && !s_reg.check_start |=> s_reg.check_start && s_reg.addr == 16'h0000)
        else $error("start from rest did not launch at address zero");

    // a zero start bit stops the engine at once
    a_stop_disables: assert property (@(posedge clock) disable iff (rst)
        clk_en && bus.wr && sel_ctrl && !bus.wdata[FCC_START_BIT]
        |=> s_reg.state == FCC_IDLE && !s_reg.check_start)
        else $error("zero start bit left the engine running");

    // a second start leaves the running sequence alone
    a_start_ignored: assert property (@(posedge clock) disable iff (rst)
        clk_en && s_reg.state != FCC_IDLE && bus.wr && sel_ctrl && bus.wdata[FCC_START_BIT]
        && !done_now |=> s_reg.state != FCC_IDLE
        && s_reg.addr == $past(s_reg.addr) + {15'h0000, ($past(s_reg.state) == FCC_WAIT)})
        else $error("restart disturbed running check");

    // completion irq only with both enables
    a_irq_gate: assert property (@(posedge clock) disable iff (rst)
        check_irq |-> shared_irq_enable && s_reg.check_irq_enable)
        else $error("irq raised without both enables");

    // done with both enables always reaches the irq line
    a_irq_follows: assert property (@(posedge clock) disable iff (rst)
        s_reg.check_done_flag && s_reg.check_irq_enable && shared_irq_enable |-> irq)
        else $error("enabled completion did not reach the irq line");

    // fetches only in free flash cycles
    a_fetch_free: assert property (@(posedge clock) disable iff (rst)
        flash.req |-> !flash_busy)
        else $error("fetch while cpu owns flash");

    // address steps by one after each folded byte
    a_addr_step: assert property (@(posedge clock) disable iff (rst)
        clk_en && s_reg.state == FCC_WAIT && !done_now && !bus.wr
        |=> s_reg.addr == $past(s_reg.addr) + 16'h0001)
        else $error("address did not advance by one");

    // each folded byte lands in the result
    a_result_fold: assert property (@(posedge clock) disable iff (rst)
        clk_en && s_reg.state == FCC_WAIT && !(bus.wr && (sel_lo || sel_hi))
        |=> s_reg.check_result_value == $past(crc_step))
        else $error("folded byte missing from result");

    // result holds outside folding and software writes
    a_result_held: assert property (@(posedge clock) disable iff (rst)
        clk_en && s_reg.state != FCC_WAIT && !(bus.wr && (sel_lo || sel_hi))
        |=> s_reg.check_result_value == $past(s_reg.check_result_value))
        else $error("result changed outside a fold");

    // span ends for the two lowest range codes
    a_range_last: assert property (@(posedge clock) disable iff (rst)
        s_reg.check_range_select == 4'h0 |-> last_addr == 16'h07fd)
        else $error("span end wrong");
    a_range_wide: assert property (@(posedge clock) disable iff (rst)
        s_reg.check_range_select == 4'h1 |-> last_addr == 16'h0ffd)
        else $error("span end wrong for the second range");

    // the key value arms the next write
    a_key_arms: assert property (@(posedge clock) disable iff (rst)
        clk_en && bus.wr && sel_key && bus.wdata == FCC_SUSPEND_KEY_VALUE && !wake_now
        |=> s_reg.key_armed)
        else $error("key write did not arm the request");

    // any other next write throws the key away
    a_key_cleared: assert property (@(posedge clock) disable iff (rst)
        clk_en && bus.wr && !sel_key && !(sel_power_control && s_reg.key_armed)
        |=> s_reg.suspend_key == FCC_BYTE_RESET && !s_reg.key_armed)
        else $error("key kept after a wrong next write");

    // neither request bit moves without the key
    a_key_needed: assert property (@(posedge clock) disable iff (rst)
        clk_en && bus.wr && sel_power_control && !s_reg.key_armed && !s_reg.idle_request_bit
        |=> !s_reg.idle_request_bit)
        else $error("idle entered without key");
    a_pdown_key: assert property (@(posedge clock) disable iff (rst)
        clk_en && bus.wr && sel_power_control && !s_reg.key_armed && !s_reg.powerdown_request_bit
        |=> !s_reg.powerdown_request_bit)
        else $error("power-down entered without key");

    // a wake ends the suspend state
    a_wake_clears: assert property (@(posedge clock) disable iff (rst)
        clk_en && wake_now |=> !s_reg.idle_request_bit && !s_reg.powerdown_request_bit)
        else $error("wake left request bits set");

    // reset ends the suspend state and drops the key
    a_reset_clears: assert property (@(posedge clock)
        rst |=> !s_reg.idle_request_bit && !s_reg.powerdown_request_bit
        && s_reg.suspend_key == FCC_BYTE_RESET)
        else $error("reset left suspend state behind");

    // ------------------------------------------------------------
    // cover points
    // ------------------------------------------------------------
    c_check_done: cover property (@(posedge clock) disable iff (rst) done_now);
    c_idle_entry: cover property (@(posedge clock) disable iff (rst)
        $rose(s_reg.idle_request_bit));
    c_idle_wake: cover property (@(posedge clock) disable iff (rst)
        s_reg.idle_request_bit && wake_now);
    c_restart_ignored: cover property (@(posedge clock) disable iff (rst)
        s_reg.state != FCC_IDLE && bus.wr && sel_ctrl && bus.wdata[FCC_START_BIT]);
    c_pdown_wake: cover property (@(posedge clock) disable iff (rst)
        s_reg.powerdown_request_bit && wake_now);
endmodule

// ### testbench/fcc_flash_model.sv
// partner model: program flash shared with a cpu that holds the port now and then
`timescale 1ns/10ps
module fcc_flash_model
    import fcc_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire fcc_flash_req_t flash,
    input wire logic cpu_idle,
    output logic flash_busy,
    output logic [7:0] flash_data,
    output logic model_bad
);
    logic [2:0] cpu_phase = 3'h0;
    // cpu claims the flash port two cycles in every eight, never while it idles
    always @(posedge clock) begin
        cpu_phase <= rst ? 3'h0 : cpu_phase + 3'h1;
    end
    assign flash_busy = !cpu_idle
        && ((cpu_phase == 3'h5) || (cpu_phase == 3'h6));
    // byte valid only in the cycle after a fetch, scrambled otherwise
    always @(posedge clock) begin
        if (rst) begin
            flash_data <= 8'h00;
        end else if (flash.req === 1'b1) begin
            flash_data <= flash.addr[7:0] ^ flash.addr[15:8] ^ 8'h3c;
        end else begin
            flash_data <= ~flash_data;
        end
    end
    // a fetch while the cpu holds the port is a fault
    always @(posedge clock) begin
        if (rst) begin
            model_bad <= 1'b0;
        end else if (flash.req === 1'b1 && flash_busy) begin
            model_bad <= 1'b1;
        end
    end
endmodule

// ### testbench/fcc_checker_bench.sv
// testbench: register-level tests of the flash code checker
`timescale 1ns/10ps
module fcc_checker_bench;
    import fcc_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    fcc_bus_t bus = '0;
    logic shared_irq_enable = 1'b0;
    logic other_wake_irq = 1'b0;
    logic clk_en = 1'b1;
    logic [7:0] rdata, flash_data;
    fcc_flash_req_t flash;
    logic flash_busy, check_irq, irq, idle_active, powerdown_active, model_bad;
    logic [15:0] crc;
    int err_count = 0;
    int total_checks = 0;
    int cycles = 0;

    initial forever #12.5 clock = ~clock;

    fcc_checker DUT (.clock(clock), .rst(rst), .clk_en(clk_en), .bus(bus), .rdata(rdata),
        .flash(flash), .flash_busy(flash_busy), .flash_data(flash_data),
        .shared_irq_enable(shared_irq_enable), .other_wake_irq(other_wake_irq),
        .check_irq(check_irq), .irq(irq), .idle_active(idle_active),
        .powerdown_active(powerdown_active));
    fcc_flash_model flash_model (.clock(clock), .rst(rst), .flash(flash), .cpu_idle(idle_active),
        .flash_busy(flash_busy), .flash_data(flash_data), .model_bad(model_bad));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        bus <= '0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        bus <= '0;
        #1;
        check(rdata, exp);
    endtask
    // bounded wait for the interrupt line
    task automatic wait_irq();
        for (int i = 0; i < 20000; i++) begin
            @(posedge clock);
            if (irq === 1'b1) break;
        end
        #1;
    endtask
    // reference code: ccitt polynomial, msb first, over bytes 0..last
    function automatic logic [15:0] ref_crc(input logic [15:0] seed, input logic [15:0] last);
        logic [15:0] c;
        logic [7:0] b;
        c = seed;
        for (int a = 0; a <= int'(last); a++) begin
            b = 8'(a) ^ 8'(a >> 8) ^ 8'h3c;
            for (int k = 7; k >= 0; k--) begin
                c = {c[14:0], 1'b0} ^ ((c[15] ^ b[k]) ? 16'h1021 : 16'h0000);
            end
        end
        return c;
    endfunction
    // seed, start, restart mid-run, then compare flags and result
    task automatic run(input logic [3:0] r, input logic [15:0] seed);
        wr_reg(8'had, seed[7:0]);
        wr_reg(8'hae, seed[15:8]);
        wr_reg(8'hac, {4'h8, r});
        wr_reg(8'hac, {4'h8, r});
        wait_irq();
        crc = ref_crc(seed, {1'b0, r + 4'h1, 11'h000} - 16'h0003);
        rd_reg(8'hac, {4'h4, r});
        rd_reg(8'had, crc[7:0]);
        rd_reg(8'hae, crc[15:8]);
    endtask

    // hang guard
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            err_count++;
            report_and_stop();
        end
    end

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        rd_reg(8'hac, 8'h00);
        rd_reg(8'had, 8'h00);
        rd_reg(8'hae, 8'h00);
        rd_reg(8'h8e, 8'h00);
        rd_reg(8'h87, 8'h00);
        rd_reg(8'h10, 8'h00);
        wr_reg(8'hac, 8'h80);
        wr_reg(8'hac, 8'h00);
        repeat (40) @(posedge clock);
        #1;
        check({7'h00, flash.req}, 8'h00);
        rd_reg(8'hac, 8'h00);
        $display("test reset and disable done");
        // a write while the clock enable is low must not land
        clk_en <= 1'b0;
        wr_reg(8'had, 8'ha5);
        clk_en <= 1'b1;
        rd_reg(8'had, 8'h00);
        $display("test clock enable done");
        shared_irq_enable <= 1'b1;
        wr_reg(8'hb9, 8'h01);
        run(4'h0, 16'hffff);
        check({7'h00, check_irq}, 8'h01);
        rd_reg(8'hb8, 8'h01);
        shared_irq_enable <= 1'b0;
        @(posedge clock);
        #1;
        check({7'h00, check_irq}, 8'h00);
        rd_reg(8'hac, 8'h40);
        wr_reg(8'hac, 8'h00);
        wr_reg(8'hba, 8'h03);
        rd_reg(8'hac, 8'h00);
        check({7'h00, irq}, 8'h00);
        $display("test normal run done");
        wr_reg(8'h87, 8'h01);
        rd_reg(8'h87, 8'h00);
        wr_reg(8'h8e, 8'h55);
        wr_reg(8'had, 8'h00);
        wr_reg(8'h87, 8'h01);
        rd_reg(8'h87, 8'h00);
        shared_irq_enable <= 1'b1;
        wr_reg(8'h8e, 8'h55);
        wr_reg(8'h87, 8'h01);
        #1;
        check({7'h00, idle_active}, 8'h01);
        run(4'h1, 16'h1d0f);
        check({7'h00, idle_active}, 8'h00);
        rd_reg(8'h87, 8'h00);
        wr_reg(8'hac, 8'h00);
        wr_reg(8'hba, 8'h03);
        $display("test idle run done");
        wr_reg(8'h8e, 8'h55);
        wr_reg(8'h87, 8'h02);
        #1;
        check({7'h00, powerdown_active}, 8'h01);
        other_wake_irq <= 1'b1;
        repeat (3) @(posedge clock);
        #1;
        check({7'h00, powerdown_active}, 8'h00);
        other_wake_irq <= 1'b0;
        check({7'h00, model_bad}, 8'h00);
        $display("test power-down wake done");
        report_and_stop();
    end
endmodule
